// file: logic/psp_pkg.sv
// Shared constants, types and decode helpers of the two-wire slave register port
package psp_pkg;

  // ****************************************************************
  // Byte framing
  // ****************************************************************
  localparam logic [3:0] PSP_BIT_FIRST = 4'h1;
  localparam logic [3:0] PSP_BIT_LAST = 4'h8;
  localparam logic [3:0] PSP_BIT_ACK = 4'h0;
  localparam logic PSP_DIR_WRITE = 1'h0;
  localparam logic PSP_DIR_READ = 1'h1;
  localparam logic PSP_LINE_LOW = 1'h0;

  // ****************************************************************
  // Slave address
  // ****************************************************************
  localparam logic [6:0] PSP_ADDR_RESET = 7'h68;
  localparam logic [1:0] PSP_ADDR_FIXED = 2'h3;
  localparam int PSP_ADDR_LOW_W = 5;

  // ****************************************************************
  // Write stream buffer
  // ****************************************************************
  localparam int PSP_WORD_W = 16;
  localparam int PSP_FIFO_DEPTH = 32;
  // Fill count at which every buffer slot is taken
  localparam logic [5:0] PSP_FILL_FULL = 6'h20;

  // Byte parser phase within one transaction
  typedef enum logic [2:0] {
    PH_IDLE,
    PH_ADDR,
    PH_INDEX,
    PH_DATA,
    PH_READ
  } psp_phase_type;

  // Address byte selects this device: upper seven bits against own address
  function automatic logic psp_addr_match(input logic [7:0] addr_byte, input logic [6:0] own);
    psp_addr_match = (addr_byte[7:1] == own);
  endfunction : psp_addr_match

endpackage : psp_pkg

// file: logic/psp_i2c_port.sv
// Two-wire serial slave register port: link logic, write buffer and top level
//
// Contract
// - Each byte is exactly eight bits
// - Sender releases data line during acknowledge
// - Receiver holds line low through acknowledge high
// - First byte: seven-bit address, then direction
// - Direction zero writes, one reads
// - Repeated start begins a new transaction
// - Write: address, index, data, each acknowledged
// - Device acknowledges its address, index and data bytes; data bytes are refused while the buffer is full
// - Ignore bus unless address matches own
// - Commit data on falling edge of LSB
// - Address upper two ones, default 0x68
// - New slave address applies from next address
// - Start/stop are data edges while clock high; only the start edge is detected, stop is not
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// Start detector, clocked by the falling data line
// ****************************************************************
module psp_start_det
  import psp_pkg::*;
(
  input wire logic sda_i,
  input wire logic scl_i,
  input wire logic rst_i,
  output logic start_tgl_o
);
  typedef struct packed {
    logic tgl;
  } psp_sd_type;

  psp_sd_type s;
  psp_sd_type next_s;

  // Falling data while clock high is a start or repeated start
  always_comb begin
    next_s = s;
    if (scl_i) begin
      next_s.tgl = ~s.tgl;
    end
  end

  // A toggle rather than a pulse: the link side sees it at its next edge
  always_ff @(negedge sda_i or posedge rst_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign start_tgl_o = s.tgl;
endmodule : psp_start_det

// ****************************************************************
// Receive side of the link, rising serial clock
// ****************************************************************
module psp_link_rx
  import psp_pkg::*;
(
  input wire logic scl_i,
  input wire logic rst_i,
  input wire logic sda_i,
  input wire logic start_tgl_i,
  input wire logic [6:0] own_addr_i,
  input wire logic full_i,
  input wire logic [7:0] rd_byte_i,
  output psp_phase_type phase_o,
  output logic [3:0] bitcnt_o,
  output logic [7:0] shift_o,
  output logic [7:0] index_o,
  output logic tx_msb_o,
  output logic [6:0] own_addr_o,
  output logic full_o
);
  typedef struct packed {
    logic seen;
    logic [6:0] addr_s1;
    logic [6:0] addr_s2;
    logic full_s1;
    logic full_s2;
    psp_phase_type phase;
    logic [3:0] bitcnt;
    logic [7:0] shift;
    logic [7:0] index;
    logic [7:0] tx;
  } psp_rx_type;

  psp_rx_type s;
  psp_rx_type next_s;

  // Bit sampling and byte parsing on each rising clock
  always_comb begin
    next_s = s;
    next_s.addr_s1 = own_addr_i;
    next_s.addr_s2 = s.addr_s1;
    next_s.full_s1 = full_i;
    next_s.full_s2 = s.full_s1;
    if (start_tgl_i != s.seen) begin
      // First edge after any start is address bit 7, parser restarts
      next_s.seen = start_tgl_i;
      next_s.phase = PH_ADDR;
      next_s.bitcnt = PSP_BIT_FIRST;
      next_s.shift = {7'h00, sda_i};
    end else if (s.phase == PH_IDLE) begin
      next_s.bitcnt = PSP_BIT_ACK;
    end else if (s.bitcnt != PSP_BIT_LAST) begin
      next_s.shift = {s.shift[6:0], sda_i};
      next_s.bitcnt = s.bitcnt + 4'h1;
      if (s.phase == PH_READ) begin
        next_s.tx = {s.tx[6:0], 1'h1};
      end
    end else begin
      // Ninth pulse: acknowledge slot, byte is complete
      next_s.bitcnt = PSP_BIT_ACK;
      case (s.phase)
        PH_ADDR: begin
          if (!psp_addr_match(s.shift, s.addr_s2)) begin
            next_s.phase = PH_IDLE;
          end else if (s.shift[0] == PSP_DIR_READ) begin
            next_s.phase = PH_READ;
            next_s.tx = rd_byte_i;
          end else begin
            next_s.phase = PH_INDEX;
          end
        end
        PH_INDEX: begin
          next_s.index = s.shift;
          next_s.phase = PH_DATA;
        end
        PH_DATA: begin
          // A refused byte ends the transaction for this device
          if (s.full_s2) begin
            next_s.phase = PH_IDLE;
          end
        end
        PH_READ: begin
          // Master not acknowledging means no more data wanted
          if (sda_i != PSP_LINE_LOW) begin
            next_s.phase = PH_IDLE;
          end else begin
            next_s.tx = rd_byte_i;
          end
        end
        default: begin
          next_s.phase = PH_IDLE;
        end
      endcase
    end
  end

  // Link domain state register
  always_ff @(posedge scl_i or posedge rst_i) begin
    if (rst_i) begin
      s <= '{seen: 1'h0, addr_s1: PSP_ADDR_RESET, addr_s2: PSP_ADDR_RESET, full_s1: 1'h0,
             full_s2: 1'h0, phase: PH_IDLE, bitcnt: 4'h0, shift: 8'h00, index: 8'h00,
             tx: 8'hff};
    end else begin
      s <= next_s;
    end
  end

  assign phase_o = s.phase;
  assign bitcnt_o = s.bitcnt;
  assign shift_o = s.shift;
  assign index_o = s.index;
  assign tx_msb_o = s.tx[7];
  assign own_addr_o = s.addr_s2;
  assign full_o = s.full_s2;
endmodule : psp_link_rx

// ****************************************************************
// Drive side of the link, falling serial clock
// ****************************************************************
module psp_link_tx
  import psp_pkg::*;
(
  input wire logic scl_i,
  input wire logic rst_i,
  input wire psp_phase_type phase_i,
  input wire logic [3:0] bitcnt_i,
  input wire logic [7:0] shift_i,
  input wire logic [7:0] index_i,
  input wire logic tx_msb_i,
  input wire logic [6:0] own_addr_i,
  input wire logic full_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic commit_tgl_o,
  output logic [15:0] commit_word_o,
  output logic index_tgl_o,
  output logic [7:0] index_word_o
);
  typedef struct packed {
    logic oe;
    logic commit_tgl;
    logic [15:0] commit_word;
    logic index_tgl;
    logic [7:0] index_word;
  } psp_tx_type;

  psp_tx_type s;
  psp_tx_type next_s;

  // Line changes only while the clock is low, so all driving is here
  always_comb begin
    next_s = s;
    next_s.oe = 1'h0;
    if (bitcnt_i == PSP_BIT_LAST) begin
      case (phase_i)
        PH_ADDR: begin
          next_s.oe = psp_addr_match(shift_i, own_addr_i);
        end
        PH_INDEX: begin
          next_s.oe = 1'h1;
          next_s.index_tgl = ~s.index_tgl;
          next_s.index_word = shift_i;
        end
        PH_DATA: begin
          // Full buffer: no acknowledge, master must retry later
          next_s.oe = ~full_i;
          if (!full_i) begin
            next_s.commit_tgl = ~s.commit_tgl;
            next_s.commit_word = {index_i, shift_i};
          end
        end
        default: begin
          next_s.oe = 1'h0;
        end
      endcase
    end else if (phase_i == PH_READ) begin
      next_s.oe = (tx_msb_i == PSP_LINE_LOW);
    end
  end

  // Open drain: only ever pulls low, held through the high phase
  always_ff @(negedge scl_i or posedge rst_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign sda_o = PSP_LINE_LOW;
  assign sda_oe_o = s.oe;
  assign commit_tgl_o = s.commit_tgl;
  assign commit_word_o = s.commit_word;
  assign index_tgl_o = s.index_tgl;
  assign index_word_o = s.index_word;
endmodule : psp_link_tx

// ****************************************************************
// Write stream buffer
// ****************************************************************
module psp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [CW-1:0] count;
  } psp_fifo_type;

  psp_fifo_type s;
  psp_fifo_type next_s;
  logic push;
  logic pop;

  assign in_ready_o = (s.count != FULL_COUNT);
  assign out_valid_o = (s.count != '0);
  assign out_data_o = s.mem[s.rd_ptr];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Pointers wrap at a power-of-two depth
  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.wr_ptr] = in_data_i;
      next_s.wr_ptr = s.wr_ptr + 1'h1;
    end
    if (pop) begin
      next_s.rd_ptr = s.rd_ptr + 1'h1;
    end
    if (push && !pop) begin
      next_s.count = s.count + 1'h1;
    end else if (pop && !push) begin
      next_s.count = s.count - 1'h1;
    end
  end

  // Buffer state register
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule : psp_fifo

// ****************************************************************
// Top level, system clock side
// ****************************************************************
module psp_i2c_port
  import psp_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic slave_addr_wr_i,
  input wire logic [4:0] slave_addr_low_i,
  output logic [6:0] slave_addr_o,
  output logic wr_valid_o,
  input wire logic wr_ready_i,
  output logic [7:0] wr_index_o,
  output logic [7:0] wr_data_o,
  output logic [7:0] rd_index_o,
  input wire logic [7:0] rd_data_i
);
  typedef struct packed {
    logic [6:0] slave_addr;
    logic cm_s1;
    logic cm_s2;
    logic cm_prev;
    logic ix_s1;
    logic ix_s2;
    logic ix_prev;
    logic [7:0] rd_index;
    logic [7:0] rd_hold;
    logic full;
    logic [5:0] fill;
    logic out_valid;
    logic [PSP_WORD_W-1:0] out_word;
  } psp_top_type;

  psp_top_type s;
  psp_top_type next_s;
  logic start_tgl;
  psp_phase_type phase;
  logic [3:0] bitcnt;
  logic [7:0] shift;
  logic [7:0] index;
  logic tx_msb;
  logic [6:0] link_addr;
  logic link_full;
  logic commit_tgl;
  logic [15:0] commit_word;
  logic index_tgl;
  logic [7:0] index_word;
  logic push;
  logic f_ready;
  logic f_valid;
  logic f_pop;
  logic [PSP_WORD_W-1:0] f_data;

  psp_start_det u_start (
    .sda_i(sda_i),
    .scl_i(scl_i),
    .rst_i(rst_i),
    .start_tgl_o(start_tgl)
  );

  psp_link_rx u_rx (
    .scl_i(scl_i),
    .rst_i(rst_i),
    .sda_i(sda_i),
    .start_tgl_i(start_tgl),
    .own_addr_i(s.slave_addr),
    .full_i(s.full),
    .rd_byte_i(s.rd_hold),
    .phase_o(phase),
    .bitcnt_o(bitcnt),
    .shift_o(shift),
    .index_o(index),
    .tx_msb_o(tx_msb),
    .own_addr_o(link_addr),
    .full_o(link_full)
  );

  psp_link_tx u_tx (
    .scl_i(scl_i),
    .rst_i(rst_i),
    .phase_i(phase),
    .bitcnt_i(bitcnt),
    .shift_i(shift),
    .index_i(index),
    .tx_msb_i(tx_msb),
    .own_addr_i(link_addr),
    .full_i(link_full),
    .sda_o(sda_o),
    .sda_oe_o(sda_oe_o),
    .commit_tgl_o(commit_tgl),
    .commit_word_o(commit_word),
    .index_tgl_o(index_tgl),
    .index_word_o(index_word)
  );

  psp_fifo #(
    .WIDTH(PSP_WORD_W),
    .DEPTH(PSP_FIFO_DEPTH)
  ) u_fifo (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .in_valid_i(push),
    .in_ready_o(f_ready),
    .in_data_i(commit_word),
    .out_valid_o(f_valid),
    .out_ready_i(f_pop),
    .out_data_o(f_data)
  );

  // Word is stable for a whole byte time once its toggle has crossed
  assign push = (s.cm_s2 != s.cm_prev);
  assign f_pop = !s.out_valid || wr_ready_i;

  // Toggle crossings, address register and output stage
  always_comb begin
    next_s = s;
    next_s.cm_s1 = commit_tgl;
    next_s.cm_s2 = s.cm_s1;
    next_s.cm_prev = s.cm_s2;
    next_s.ix_s1 = index_tgl;
    next_s.ix_s2 = s.ix_s1;
    next_s.ix_prev = s.ix_s2;
    // Fill mirror: full rises at the very edge that takes the last slot, so the
    // link refuses the next byte instead of acknowledging a word that is lost.
    // Holds while one byte lasts longer than three system plus two serial clocks.
    if (push && f_ready && !(f_pop && f_valid)) begin
      next_s.fill = s.fill + 6'h01;
    end else if (!(push && f_ready) && f_pop && f_valid) begin
      next_s.fill = s.fill - 6'h01;
    end
    next_s.full = (next_s.fill == PSP_FILL_FULL);
    next_s.rd_hold = rd_data_i;
    if (slave_addr_wr_i) begin
      next_s.slave_addr = {PSP_ADDR_FIXED, slave_addr_low_i};
    end
    if (s.ix_s2 != s.ix_prev) begin
      next_s.rd_index = index_word;
    end
    if (f_pop) begin
      next_s.out_valid = f_valid;
      next_s.out_word = f_data;
    end
  end

  // System clock state register
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      s <= '{slave_addr: PSP_ADDR_RESET, cm_s1: 1'h0, cm_s2: 1'h0, cm_prev: 1'h0,
             ix_s1: 1'h0, ix_s2: 1'h0, ix_prev: 1'h0, rd_index: 8'h00, rd_hold: 8'h00,
             full: 1'h0, fill: 6'h00, out_valid: 1'h0, out_word: 16'h0000};
    end else begin
      s <= next_s;
    end
  end

  assign slave_addr_o = s.slave_addr;
  assign wr_valid_o = s.out_valid;
  assign wr_index_o = s.out_word[15:8];
  assign wr_data_o = s.out_word[7:0];
  assign rd_index_o = s.rd_index;
endmodule : psp_i2c_port

`default_nettype wire

// file: tb/psp_master_model.sv
// Behavioural two-wire bus master driving serial clock and data line
`timescale 1ns/100ps
`default_nettype none
module psp_master (
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_oe_o
);
  // Clock and data idle released; clock stands still between frames
  initial begin
    scl_o = 1'h1;
    sda_oe_o = 1'h0;
  end
  // Start and repeated start: data falls while the clock is high
  task automatic start();
    sda_oe_o = 1'h0;
    #3 scl_o = 1'h1;
    #3 sda_oe_o = 1'h1;
    #6 scl_o = 1'h0;
  endtask : start
  // Only the master ends a frame: data rises while the clock is high
  task automatic stop();
    #3 sda_oe_o = 1'h1;
    #3 scl_o = 1'h1;
    #3 sda_oe_o = 1'h0;
    #6;
  endtask : stop
  // MSB first; data moves only mid clock low, 12 ns per bit
  task automatic bits(input logic [7:0] b, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      #3 sda_oe_o = ~b[i];
      #3 scl_o = 1'h1;
      #6 scl_o = 1'h0;
    end
  endtask : bits
  // Byte, then line released through the ninth pulse we clock ourselves
  task automatic wbyte(input logic [7:0] b, output logic ack);
    bits(b, 8);
    #3 sda_oe_o = 1'h0;
    #3 scl_o = 1'h1;
    #3 ack = ~sda_i;
    #3 scl_o = 1'h0;
  endtask : wbyte
  // Device sends; we answer low to continue or leave high before stop
  task automatic rbyte(input logic nack, output logic [7:0] b);
    #3 sda_oe_o = 1'h0;
    for (int i = 7; i >= 0; i--) begin
      #3 scl_o = 1'h1;
      #3 b[i] = sda_i;
      #3 scl_o = 1'h0;
      #3;
    end
    sda_oe_o = ~nack;
    #3 scl_o = 1'h1;
    #6 scl_o = 1'h0;
  endtask : rbyte
endmodule : psp_master
`default_nettype wire

// file: tb/psp_i2c_port_assertions.sv
// Port-level assertions of the two-wire slave register port
`timescale 1ns/100ps
`default_nettype none
module psp_chk
  import psp_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic slave_addr_wr_i,
  input wire logic [4:0] slave_addr_low_i,
  input wire logic [6:0] slave_addr_o,
  input wire logic wr_valid_o,
  input wire logic wr_ready_i,
  input wire logic [7:0] wr_index_o,
  input wire logic [7:0] wr_data_o
);
  // ********************
  // Link side
  // ********************
  logic oe_at_rise;
  // Drive level at the last rising serial clock
  always_ff @(posedge scl_i or posedge rst_i) begin
    if (rst_i) begin
      oe_at_rise <= 1'h0;
    end else begin
      oe_at_rise <= sda_oe_o;
    end
  end
  a_open_drain_only: assert property (@(posedge mclk_i) disable iff (rst_i)
    sda_o == PSP_LINE_LOW) else $error("data output not low");
  a_oe_steady_high: assert property (@(negedge scl_i) disable iff (rst_i)
    sda_oe_o == oe_at_rise) else $error("drive changed while clock high");
  // Read data must start with a released bit, else this would misfire
  a_ack_one_pulse: assert property (@(negedge scl_i) disable iff (rst_i)
    (!sda_oe_o) [*8] ##1 sda_oe_o |=> !sda_oe_o) else $error("ack not one pulse");
  // ********************
  // System side
  // ********************
  a_addr_top_ones: assert property (@(posedge mclk_i) disable iff (rst_i)
    slave_addr_o[6:5] == PSP_ADDR_FIXED) else $error("address top bits wrong");
  a_addr_load_new: assert property (@(posedge mclk_i) disable iff (rst_i)
    slave_addr_wr_i |=> slave_addr_o == {PSP_ADDR_FIXED, $past(slave_addr_low_i)})
    else $error("new address not loaded");
  a_addr_holds: assert property (@(posedge mclk_i) disable iff (rst_i)
    !slave_addr_wr_i |=> $stable(slave_addr_o)) else $error("address moved");
  a_offer_holds: assert property (@(posedge mclk_i) disable iff (rst_i)
    wr_valid_o && !wr_ready_i |=> wr_valid_o) else $error("offer withdrawn");
  a_offer_stable: assert property (@(posedge mclk_i) disable iff (rst_i)
    wr_valid_o && !wr_ready_i |=> $stable({wr_index_o, wr_data_o})) else $error("offer moved");
  c_ack: cover property (@(negedge scl_i) disable iff (rst_i) $rose(sda_oe_o));
  c_taken: cover property (@(posedge mclk_i) disable iff (rst_i) wr_valid_o && wr_ready_i);
  c_stall: cover property (@(posedge mclk_i) disable iff (rst_i) wr_valid_o && !wr_ready_i);
  c_addr: cover property (@(posedge mclk_i) disable iff (rst_i) slave_addr_wr_i);
endmodule : psp_chk
bind psp_i2c_port psp_chk u_chk (.mclk_i(mclk_i), .rst_i(rst_i), .scl_i(scl_i),
  .sda_o(sda_o), .sda_oe_o(sda_oe_o), .slave_addr_wr_i(slave_addr_wr_i),
  .slave_addr_low_i(slave_addr_low_i), .slave_addr_o(slave_addr_o), .wr_valid_o(wr_valid_o),
  .wr_ready_i(wr_ready_i), .wr_index_o(wr_index_o), .wr_data_o(wr_data_o));
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench of the two-wire slave register port
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import psp_pkg::*;
  logic mclk_i = 1'h0;
  logic rst_i = 1'h1;
  logic addr_wr = 1'h0;
  logic [4:0] addr_low = 5'h08;
  logic wr_ready = 1'h0;
  logic ack;
  logic [7:0] rb;
  logic [15:0] w;
  wire logic scl, sda, sda_o, sda_oe, m_oe, wr_valid;
  wire logic [6:0] own;
  wire logic [7:0] wr_index, wr_data, rd_index, rd_data;
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  always #12.5 mclk_i = ~mclk_i;
  // Pull-up on the data line: low when either party pulls
  assign sda = ~(m_oe | (sda_oe & ~sda_o));
  // Read store stand-in; top bit set keeps the first read bit released
  assign rd_data = {1'h1, rd_index[6:0] ^ 7'h15};
  psp_master m (.sda_i(sda), .scl_o(scl), .sda_oe_o(m_oe));
  psp_i2c_port DUT (.mclk_i(mclk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_o(sda_oe), .slave_addr_wr_i(addr_wr), .slave_addr_low_i(addr_low),
    .slave_addr_o(own), .wr_valid_o(wr_valid), .wr_ready_i(wr_ready), .wr_index_o(wr_index),
    .wr_data_o(wr_data), .rd_index_o(rd_index), .rd_data_i(rd_data));
  // ********************
  // Shared tasks
  // ********************
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tick();
    @(posedge mclk_i);
    #2;
  endtask : tick
  // Stalls a cycle, waits bounded for an offer, takes it for one cycle
  task automatic take();
    int k;
    k = 0;
    tick();
    while (wr_valid !== 1'h1 && k < 40) begin
      tick();
      k++;
    end
    check("wr_valid_o", 16'(wr_valid), 16'h1);
    w = {wr_index, wr_data};
    wr_ready = 1'h1;
    tick();
    wr_ready = 1'h0;
  endtask : take
  task automatic wr(input logic [6:0] a, input logic [7:0] i, input logic [7:0] d, logic e);
    m.start();
    m.wbyte({a, PSP_DIR_WRITE}, ack);
    check("addr ack", 16'(ack), 16'(e));
    m.wbyte(i, ack);
    check("index ack", 16'(ack), 16'(e));
    m.wbyte(d, ack);
    check("data ack", 16'(ack), 16'(e));
    m.stop();
  endtask : wr
  task automatic set_addr(input logic [4:0] low);
    addr_low = low;
    addr_wr = 1'h1;
    tick();
    addr_wr = 1'h0;
    check("slave_addr_o", 16'(own), 16'({2'h3, low}));
  endtask : set_addr
  // ********************
  // Scenarios
  // ********************
  task automatic t_reset();
    check("reset address", 16'(own), 16'h68);
    check("reset drive", 16'(sda_oe), 16'h0);
    $display("reset test done");
  endtask : t_reset
  task automatic t_write();
    wr(7'h68, 8'h5c, 8'ha3, 1'h1);
    take();
    check("write word", w, 16'h5ca3);
    $display("write test done");
  endtask : t_write
  task automatic t_nomatch();
    wr(7'h69, 8'h11, 8'h22, 1'h0);
    repeat (20) tick();
    check("foreign write", 16'(wr_valid), 16'h0);
    $display("address mismatch test done");
  endtask : t_nomatch
  task automatic t_read();
    m.start();
    m.wbyte({7'h68, PSP_DIR_WRITE}, ack);
    m.wbyte(8'h3c, ack);
    m.start();
    m.wbyte({7'h68, PSP_DIR_READ}, ack);
    check("read addr ack", 16'(ack), 16'h1);
    m.rbyte(1'h1, rb);
    m.stop();
    check("rd_index_o", 16'(rd_index), 16'h3c);
    check("read byte", 16'(rb), 16'({1'h1, 7'h3c ^ 7'h15}));
    check("read no write", 16'(wr_valid), 16'h0);
    $display("read test done");
  endtask : t_read
  task automatic t_restart();
    m.start();
    m.wbyte({7'h68, PSP_DIR_WRITE}, ack);
    m.bits(8'hff, 3);
    wr(7'h68, 8'h0f, 8'h96, 1'h1);
    take();
    check("restart word", w, 16'h0f96);
    $display("repeated start test done");
  endtask : t_restart
  task automatic t_addr();
    set_addr(5'h0a);
    wr(7'h68, 8'h01, 8'h02, 1'h0);
    wr(7'h6a, 8'h21, 8'hc4, 1'h1);
    take();
    check("new address word", w, 16'h21c4);
    set_addr(5'h08);
    $display("address change test done");
  endtask : t_addr
  // Consumer stalled until the device refuses, then drained to empty
  task automatic t_full();
    int na;
    na = 0;
    m.start();
    m.wbyte({7'h68, PSP_DIR_WRITE}, ack);
    m.wbyte(8'h44, ack);
    while (na < 40) begin
      m.wbyte(8'h80 + 8'(na), ack);
      if (ack !== 1'h1) break;
      na++;
    end
    m.wbyte(8'h01, ack);
    check("after refusal", 16'(ack), 16'h0);
    m.stop();
    check("accepted", 16'(na), 16'h0021);
    for (int i = 0; i < na; i++) begin
      take();
      check("drained word", w, {8'h44, 8'h80 + 8'(i)});
    end
    repeat (4) tick();
    check("empty", 16'(wr_valid), 16'h0);
    $display("buffer full test done");
  endtask : t_full
  task automatic print_verdict();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict
  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      $display("[FAIL] cycles expected below 20000 seen %0d", cycles);
      print_verdict();
    end
  end
  initial begin
    repeat (10) @(posedge mclk_i);
    #2 rst_i = 1'h0;
    tick();
    tick();
    t_reset();
    t_write();
    t_nomatch();
    t_read();
    t_restart();
    t_addr();
    t_full();
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
